// *** core/wss_pkg.sv ***
package wss_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_MHZ            = 200;
	localparam int unsigned STALE_TIME_S       = 10;
	localparam int unsigned STATIC_TIME_S      = 60;
	localparam int unsigned AVG_SPLIT_S        = 10;
	// one second in clock cycles, default of the tick parameter
	localparam int unsigned SEC_CYCLES         = CLK_MHZ * 1000000;
	localparam int unsigned CNT_W              = 8;

	// ------------------------------------------------------------
	// widths and field positions
	// ------------------------------------------------------------
	localparam int unsigned FILL_W             = 16;
	localparam int unsigned AVG_W              = 16;
	localparam int unsigned CODE_W             = 3;
	localparam int unsigned CMP_GEN_BIT        = 0;
	localparam int unsigned CMP_FILL_LSB       = 1;
	localparam int unsigned CMP_RSV_BIT        = 4;
	localparam int unsigned CMP_STATIC_BIT     = 5;
	localparam int unsigned CMP_HCRIT_BIT      = 6;
	localparam int unsigned CMP_HON_BIT        = 7;
	localparam int unsigned OP_FILL_LSB        = 1;
	localparam int unsigned OP_HCRIT_BIT       = 5;
	localparam int unsigned OP_HON_BIT         = 6;
	localparam int unsigned ERR_GEN_BIT        = 0;
	localparam int unsigned ERR_STATIC_BIT     = 1;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  STATUS_RST         = 8'h00;
	localparam logic [CNT_W-1:0] CNT_RST       = 8'h00;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [FILL_W-1:0] fill;     // values held in averaging buffer
		logic [FILL_W-1:0] depth;    // buffer capacity
		logic [AVG_W-1:0]  avg_s;    // averaging time in seconds
	} wss_buf_t;

	typedef struct packed {
		logic crit;                  // heater switch-on criterion
		logic on;                    // heater energised
	} wss_heat_t;

	typedef struct packed {
		logic [7:0] compact;
		logic [7:0] op;
		logic [7:0] err;
	} wss_bytes_t;
endpackage

// *** core/wss_fill_code.sv ***
`timescale 1ns/10ps
module wss_fill_code (
	input  wire logic [wss_pkg::FILL_W-1:0] fill,
	input  wire logic [wss_pkg::FILL_W-1:0] depth,
	output logic      [wss_pkg::CODE_W-1:0] code
);
	// ------------------------------------------------------------
	// eighth-step occupancy code: n/8 < fill/depth <= (n+1)/8
	// ------------------------------------------------------------
	logic [wss_pkg::FILL_W+2:0] f8;
	always_comb begin
		f8   = {fill, 3'h0};
		code = 3'h0;
		// largest n with 8*fill > n*depth
		for (int n = 1; n < 8; n++) begin
			if (f8 > (19'(depth) * 19'(n)))
				code = 3'(n);
		end
	end
endmodule

// *** core/wss_sec_tick.sv ***
`timescale 1ns/10ps
module wss_sec_tick #(
	parameter int unsigned PERIOD = wss_pkg::SEC_CYCLES
) (
	input  wire logic clk,
	input  wire logic rst,
	output logic      tick
);
	// ------------------------------------------------------------
	// one-second strobe
	// ------------------------------------------------------------
	logic [31:0] cnt_ff;
	always_ff @(posedge clk) begin
		if (rst || cnt_ff == PERIOD - 1)
			cnt_ff <= 32'h0;
		else
			cnt_ff <= cnt_ff + 32'h1;
	end
	assign tick = (cnt_ff == PERIOD - 1);
endmodule

// *** core/wss_status.sv ***
`timescale 1ns/10ps
// Operation
// - averaging under 10 s: general fault if no new value for 10 s
// - averaging 10 s or more: general fault if buffer under half of expected
// - compact bits 1..3 carry eighth-step buffer occupancy code
// - compact bit 5 set on static fault lasting over one minute
// - compact bit 6 follows heater switch-on criterion
// - compact bit 7 follows heater energised
// - separate regional operating and error status bytes are produced
// - regional operating bits 1..3 carry same occupancy code
// - regional operating bit 5 follows heater switch-on criterion
// - regional operating bit 6 follows heater energised
// - regional error bit 0 general fault, bit 1 static, rest zero
module wss_status #(
	parameter int unsigned SEC_PERIOD = wss_pkg::SEC_CYCLES
) (
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic                new_value,
	input  wire logic                vt_limit_viol,
	input  wire wss_pkg::wss_buf_t   buf_info,
	input  wire wss_pkg::wss_heat_t  heat,
	output wss_pkg::wss_bytes_t      status,
	output logic                     general_fault,
	output logic                     static_fault
);
	// ------------------------------------------------------------
	// input capture (pins from the measurement side)
	// ------------------------------------------------------------
	logic                 nv_s1_ff, nv_s2_ff, nv_s3_ff;
	logic                 vt_s1_ff, vt_s2_ff;
	logic                 hc_s1_ff, hc_s2_ff, ho_s1_ff, ho_s2_ff;
	wss_pkg::wss_buf_t    buf_s1_ff, buf_s2_ff;

	// new-value level, third stage kept only for edge detection
	always_ff @(posedge clk) begin
		if (rst) begin
			nv_s1_ff <= 1'b0;
			nv_s2_ff <= 1'b0;
			nv_s3_ff <= 1'b0;
		end else begin
			nv_s1_ff <= new_value;
			nv_s2_ff <= nv_s1_ff;
			nv_s3_ff <= nv_s2_ff;
		end
	end

	// limit violation level, stage one read only by stage two
	always_ff @(posedge clk) begin
		if (rst) begin
			vt_s1_ff <= 1'b0;
			vt_s2_ff <= 1'b0;
		end else begin
			vt_s1_ff <= vt_limit_viol;
			vt_s2_ff <= vt_s1_ff;
		end
	end

	// heater criterion and energised levels
	always_ff @(posedge clk) begin
		if (rst) begin
			hc_s1_ff <= 1'b0;
			hc_s2_ff <= 1'b0;
			ho_s1_ff <= 1'b0;
			ho_s2_ff <= 1'b0;
		end else begin
			hc_s1_ff <= heat.crit;
			hc_s2_ff <= hc_s1_ff;
			ho_s1_ff <= heat.on;
			ho_s2_ff <= ho_s1_ff;
		end
	end

	// buffer description, quasi-static: held stable by the source
	always_ff @(posedge clk) begin
		if (rst) begin
			buf_s1_ff <= '0;
			buf_s2_ff <= '0;
		end else begin
			buf_s1_ff <= buf_info;
			buf_s2_ff <= buf_s1_ff;
		end
	end

	// rising edge of the new-value level marks a fresh measurement
	logic nv_pulse;
	assign nv_pulse = nv_s2_ff & ~nv_s3_ff;

	// ------------------------------------------------------------
	// second strobe
	// ------------------------------------------------------------
	logic sec_tick;
	wss_sec_tick #(
		.PERIOD (SEC_PERIOD)
	) u_tick (
		.clk  (clk),
		.rst  (rst),
		.tick (sec_tick)
	);

	// ------------------------------------------------------------
	// saturating seconds increment, shared by both timers
	// ------------------------------------------------------------
	function automatic logic [wss_pkg::CNT_W-1:0] sat_inc(
		input logic [wss_pkg::CNT_W-1:0] v,
		input logic                      step
	);
		if (step && v != {wss_pkg::CNT_W{1'b1}})
			return v + 8'h01;
		return v;
	endfunction

	// seconds since last new measured value
	logic [wss_pkg::CNT_W-1:0] stale_ff;
	always_ff @(posedge clk) begin
		if (rst)
			stale_ff <= wss_pkg::CNT_RST;
		else if (nv_pulse)
			stale_ff <= wss_pkg::CNT_RST;
		else
			stale_ff <= sat_inc(stale_ff, sec_tick);
	end

	// ------------------------------------------------------------
	// general malfunction
	// ------------------------------------------------------------
	logic under_half;
	logic short_avg;
	logic nxt_gen;
	logic gen_ff;
	// below half of avg_s once-per-second values: 2*fill < avg_s
	assign under_half = ({1'b0, buf_s2_ff.fill, 1'b0} < {2'b00, buf_s2_ff.avg_s});
	assign short_avg  = (buf_s2_ff.avg_s < 16'(wss_pkg::AVG_SPLIT_S));

	always_comb begin
		if (short_avg)
			nxt_gen = (stale_ff >= 8'(wss_pkg::STALE_TIME_S));
		else
			nxt_gen = under_half;
	end

	always_ff @(posedge clk) begin
		if (rst)
			gen_ff <= 1'b0;
		else
			gen_ff <= nxt_gen;
	end

	// ------------------------------------------------------------
	// static malfunction: cause held longer than one minute
	// ------------------------------------------------------------
	logic                      static_cause;
	logic [wss_pkg::CNT_W-1:0] stat_ff;
	logic                      static_ff;
	// persistent limit violation or no measured values
	assign static_cause = vt_s2_ff | (stale_ff != wss_pkg::CNT_RST);

	always_ff @(posedge clk) begin
		if (rst)
			stat_ff <= wss_pkg::CNT_RST;
		else if (!static_cause)
			stat_ff <= wss_pkg::CNT_RST;
		else
			stat_ff <= sat_inc(stat_ff, sec_tick);
	end

	always_ff @(posedge clk) begin
		if (rst)
			static_ff <= 1'b0;
		else
			static_ff <= (stat_ff > 8'(wss_pkg::STATIC_TIME_S));
	end

	// ------------------------------------------------------------
	// occupancy code
	// ------------------------------------------------------------
	logic [wss_pkg::CODE_W-1:0] fill_code;
	wss_fill_code u_code (
		.fill  (buf_s2_ff.fill),
		.depth (buf_s2_ff.depth),
		.code  (fill_code)
	);

	// ------------------------------------------------------------
	// byte assembly
	// ------------------------------------------------------------
	logic [7:0] nxt_compact, nxt_op, nxt_err;
	always_comb begin
		nxt_compact = 8'h00;
		nxt_compact[wss_pkg::CMP_GEN_BIT]  = nxt_gen;
		nxt_compact[wss_pkg::CMP_FILL_LSB +: wss_pkg::CODE_W] = fill_code;
		nxt_compact[wss_pkg::CMP_STATIC_BIT] = static_ff;
		nxt_compact[wss_pkg::CMP_HCRIT_BIT]  = hc_s2_ff;
		nxt_compact[wss_pkg::CMP_HON_BIT]    = ho_s2_ff;
		nxt_op = 8'h00;
		nxt_op[wss_pkg::OP_FILL_LSB +: wss_pkg::CODE_W] = fill_code;
		nxt_op[wss_pkg::OP_HCRIT_BIT] = hc_s2_ff;
		nxt_op[wss_pkg::OP_HON_BIT]   = ho_s2_ff;
		nxt_err = 8'h00;
		nxt_err[wss_pkg::ERR_GEN_BIT]    = nxt_gen;
		nxt_err[wss_pkg::ERR_STATIC_BIT] = static_ff;
	end

	// three independent registered bytes
	logic [7:0] compact_ff, op_ff, err_ff;

	// compact byte register
	always_ff @(posedge clk) begin
		if (rst)
			compact_ff <= wss_pkg::STATUS_RST;
		else
			compact_ff <= nxt_compact;
	end

	// regional operating byte register
	always_ff @(posedge clk) begin
		if (rst)
			op_ff <= wss_pkg::STATUS_RST;
		else
			op_ff <= nxt_op;
	end

	// regional error byte register
	always_ff @(posedge clk) begin
		if (rst)
			err_ff <= wss_pkg::STATUS_RST;
		else
			err_ff <= nxt_err;
	end

	// one driver for the whole status carrier
	assign status        = '{compact: compact_ff, op: op_ff, err: err_ff};
	assign general_fault = gen_ff;
	assign static_fault  = static_ff;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	cmp_rsv_zero_a: assert property (@(posedge clk) disable iff (rst)
		!compact_ff[wss_pkg::CMP_RSV_BIT] && !op_ff[0] && !op_ff[4] && !op_ff[7])
		else $error("reserved status bit set");
	err_upper_zero_a: assert property (@(posedge clk) disable iff (rst)
		err_ff[7:2] == 6'h00 && err_ff[1:0] == {$past(static_ff), gen_ff})
		else $error("error byte mismatch");
	fill_same_a: assert property (@(posedge clk) disable iff (rst)
		op_ff[3:1] == compact_ff[3:1])
		else $error("fill codes differ");
	fill_code_a: assert property (@(posedge clk) disable iff (rst)
		compact_ff[3:1] == $past(fill_code))
		else $error("fill code not registered");
	hcrit_track_a: assert property (@(posedge clk) disable iff (rst)
		compact_ff[6] == $past(hc_s2_ff))
		else $error("criterion bit wrong");
	hon_track_a: assert property (@(posedge clk) disable iff (rst)
		compact_ff[7] == $past(ho_s2_ff))
		else $error("heater bit wrong");
	op_heat_a: assert property (@(posedge clk) disable iff (rst)
		op_ff[5] == compact_ff[6] && op_ff[6] == compact_ff[7])
		else $error("operating heater bits wrong");
	stale_gen_a: assert property (@(posedge clk) disable iff (rst)
		short_avg && $stable(short_avg) && stale_ff >= 8'(wss_pkg::STALE_TIME_S)
		|=> compact_ff[0])
		else $error("stale value not flagged");
	half_gen_a: assert property (@(posedge clk) disable iff (rst)
		!short_avg && under_half |=> compact_ff[0])
		else $error("low buffer not flagged");
	static_min_a: assert property (@(posedge clk) disable iff (rst)
		static_ff |-> $past(stat_ff) > 8'(wss_pkg::STATIC_TIME_S))
		else $error("static fault too early");
	op_sep_a: assert property (@(posedge clk) disable iff (rst)
		op_ff[6] == $past(ho_s2_ff))
		else $error("operating heater on wrong");
	op_err_sep_a: assert property (@(posedge clk) disable iff (rst)
		err_ff[0] == compact_ff[0] && err_ff[1] == compact_ff[5])
		else $error("error byte diverged");
	// stale timer and general flag
	stale_reset_a: assert property (@(posedge clk) disable iff (rst)
		nv_pulse |=> stale_ff == wss_pkg::CNT_RST)
		else $error("stale counter not cleared");
	stale_step_a: assert property (@(posedge clk) disable iff (rst)
		sec_tick && !nv_pulse && stale_ff != 8'hFF
		|=> stale_ff == $past(stale_ff) + 8'h01)
		else $error("stale counter missed a second");
	stale_clear_a: assert property (@(posedge clk) disable iff (rst)
		short_avg && stale_ff < 8'(wss_pkg::STALE_TIME_S) |=> !compact_ff[0])
		else $error("general fault without stale value");
	half_clear_a: assert property (@(posedge clk) disable iff (rst)
		!short_avg && !under_half |=> !compact_ff[0])
		else $error("general fault with buffer half full");
	// static malfunction
	static_bit_a: assert property (@(posedge clk) disable iff (rst)
		static_ff |=> compact_ff[wss_pkg::CMP_STATIC_BIT])
		else $error("static fault not in compact byte");
	static_drop_a: assert property (@(posedge clk) disable iff (rst)
		!static_cause |-> ##2 !static_ff)
		else $error("static fault outlived its cause");
	// operating byte heater criterion
	op_hcrit_a: assert property (@(posedge clk) disable iff (rst)
		op_ff[wss_pkg::OP_HCRIT_BIT] == $past(hc_s2_ff))
		else $error("operating criterion bit wrong");

	gen_seen_c: cover property (@(posedge clk) disable iff (rst) $rose(gen_ff));
	static_seen_c: cover property (@(posedge clk) disable iff (rst) $rose(static_ff));
	full_seen_c: cover property (@(posedge clk) disable iff (rst) compact_ff[3:1] == 3'h7);
	heat_seen_c: cover property (@(posedge clk) disable iff (rst) compact_ff[7:6] == 2'h3);
	stale_gen_c: cover property (@(posedge clk) disable iff (rst) short_avg && compact_ff[0]);
endmodule

// *** tb/wss_logger.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------
// host side: latches the status bytes on each poll
// ------------------------------------------------------------
module wss_logger (
	input  wire logic                clk,
	input  wire logic                poll,
	input  wire wss_pkg::wss_bytes_t status,
	output wss_pkg::wss_bytes_t      seen
);
	// one telegram read per poll, held until the next
	always_ff @(posedge clk) begin
		if (poll) begin
			seen <= status;
		end
	end
endmodule

// *** tb/test_wss_status.sv ***
`timescale 1ns/10ps
module test_wss_status;
	localparam int unsigned SEC = 20;
	logic                clk           = 1'b0;
	logic                rst           = 1'b1;
	logic                new_value     = 1'b0;
	logic                vt_limit_viol = 1'b0;
	logic                pulse_en      = 1'b0;
	logic                poll          = 1'b0;
	wss_pkg::wss_buf_t   buf_info      = '0;
	wss_pkg::wss_heat_t  heat          = '0;
	wss_pkg::wss_bytes_t status;
	wss_pkg::wss_bytes_t seen;
	logic                general_fault;
	logic                static_fault;
	int                  err_count     = 0;
	int                  compares      = 0;
	int                  cycles        = 0;

	wss_status #(.SEC_PERIOD(SEC)) dut (
		.clk           (clk),
		.rst           (rst),
		.new_value     (new_value),
		.vt_limit_viol (vt_limit_viol),
		.buf_info      (buf_info),
		.heat          (heat),
		.status        (status),
		.general_fault (general_fault),
		.static_fault  (static_fault)
	);

	wss_logger host (
		.clk    (clk),
		.poll   (poll),
		.status (status),
		.seen   (seen)
	);

	// clock, 5 ns period
	always #2.5 clk = ~clk;

	// measurement source: a new value every 10 cycles when enabled
	always begin
		repeat (5) @(posedge clk);
		#1 new_value = pulse_en & ~new_value;
	end

	// hang guard
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 4000) begin
			err_count = err_count + 1;
			finish_test();
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		compares = compares + 1;
		if (got !== exp) begin
			err_count = err_count + 1;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// one read by the host model
	task automatic sample();
		poll = 1'b1;
		cyc(1);
		poll = 1'b0;
	endtask

	// occupancy codes, heater bits and the half-full fault
	task automatic test_fill();
		logic [15:0] fills [12] = '{16'h0000, 16'h0004, 16'h0005, 16'h0008, 16'h0009,
			16'h0010, 16'h0011, 16'h0020, 16'h0021, 16'h0038, 16'h0039, 16'h0040};
		logic [2:0]  codes [12] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h3,
			3'h4, 3'h6, 3'h7, 3'h7};
		logic        gen;
		for (int i = 0; i < 12; i++) begin
			buf_info = '{fill: fills[i], depth: 16'h0040, avg_s: 16'h000A};
			heat = wss_pkg::wss_heat_t'(i[1:0]);
			gen = (fills[i] < 16'h0005);
			cyc(5);
			sample();
			check(seen.compact, {heat.on, heat.crit, 2'h0, codes[i], gen});
			check(seen.op, {1'h0, heat.on, heat.crit, 1'h0, codes[i], 1'h0});
			check(seen.err, {7'h00, gen});
			check({7'h00, general_fault}, {7'h00, gen});
		end
		$display("test fill done");
	endtask

	// no new value for 10 s under short averaging
	task automatic test_stale();
		buf_info = '{fill: 16'h0000, depth: 16'h0040, avg_s: 16'h0005};
		pulse_en = 1'b0;
		cyc(8 * SEC + 5);
		sample();
		check({7'h00, seen.compact[0]}, 8'h00);
		cyc(3 * SEC + 10);
		sample();
		check({7'h00, seen.compact[0]}, 8'h01);
		check(seen.err, 8'h01);
		pulse_en = 1'b1;
		cyc(20);
		check({7'h00, general_fault}, 8'h00);
		$display("test stale done");
	endtask

	// lasting limit violation becomes static after one minute
	task automatic test_static();
		vt_limit_viol = 1'b1;
		cyc(55 * SEC);
		sample();
		check({7'h00, static_fault}, 8'h00);
		cyc(9 * SEC);
		sample();
		check({7'h00, static_fault}, 8'h01);
		check({7'h00, seen.compact[5]}, 8'h01);
		check(seen.err, 8'h02);
		vt_limit_viol = 1'b0;
		cyc(10);
		sample();
		check({7'h00, seen.compact[5]}, 8'h00);
		$display("test static done");
	endtask

	// reset clears every byte and flag, at start and in mid-run
	task automatic test_reset();
		rst = 1'b1;
		cyc(1);
		sample();
		check(seen.compact, 8'h00);
		check(seen.op, 8'h00);
		check(seen.err, 8'h00);
		check({6'h00, general_fault, static_fault}, 8'h00);
		rst = 1'b0;
		$display("test reset done");
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		test_reset();
		pulse_en = 1'b1;
		test_fill();
		test_reset();
		test_stale();
		test_static();
		finish_test();
	end
endmodule
